/* dv/pis_host_model.sv */
// Purpose: host model driving the shifter pins
// Assumes: pins change only just after a sys_clk rise
// Notes:   levels are held 4 cycles so the 2-flop sampling always sees them
`timescale 1ns/10ps

module pis_host_model
(
	input  wire logic          sys_clk,
	output pis_pkg::pis_pins_s pins
);
	initial pins = '{shift_load_n: 1'h1, default: '0};

	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// shift clock toggles during the load, which must not disturb it
	task automatic load(input logic [pis_pkg::PIS_STAGES-1:0] d,
		input logic [pis_pkg::PIS_STAGES-1:0] d2);
		pins.shift_load_n <= 1'h0;
		pins.shift_clk    <= 1'h1;
		hold(1);
		pins.par_in       <= d;
		hold(4);
		pins.par_in       <= d2;
		pins.shift_clk    <= 1'h0;
		hold(4);
		pins.shift_load_n <= 1'h1;
		hold(4);
		// inputs move only once shift mode is seen, so this must not leak in
		pins.par_in       <= ~d2;
		hold(4);
	endtask

	// serial data is inverted once its hold time has run out
	task automatic shift(input logic use_inh, input logic s);
		pins.serial_in <= s;
		hold(2);
		if (use_inh)
			pins.clock_inhibit <= 1'h1;
		else
			pins.shift_clk <= 1'h1;
		hold(4);
		pins.shift_clk     <= 1'h0;
		pins.clock_inhibit <= 1'h0;
		pins.serial_in     <= ~s;
		hold(4);
	endtask

	task automatic quiet();
		pins.shift_clk     <= 1'h1;
		hold(4);
		pins.clock_inhibit <= 1'h1;
		hold(4);
		pins.shift_clk     <= 1'h0;
		hold(4);
		pins.shift_clk     <= 1'h1;
		hold(4);
		pins.shift_clk     <= 1'h0;
		hold(4);
		pins.clock_inhibit <= 1'h0;
		hold(4);
	endtask
endmodule

/* dv/pis_shifter_tb.sv */
// Purpose: self-checking bench for the parallel-in shifter
// Assumes: ce high apart from a short freeze after each load
// Notes:   only the last stage is visible, so stages are read by shifting
`timescale 1ns/10ps
`define CHK(nm, e, a) \
	begin \
		tests_run++; \
		if ((a) !== (e)) \
		begin \
			err_count++; \
			$display("[ERR] %s exp %b got %b", nm, e, a); \
		end \
	end

module pis_shifter_tb;
	localparam int N = pis_pkg::PIS_STAGES;
	logic               sys_clk;
	logic               rst;
	logic               ce;
	pis_pkg::pis_pins_s pins;
	logic               serial_out;
	logic               serial_out_inverted;
	logic [N-1:0]       exp_q;
	logic               s;
	logic               m;
	int                 err_count;
	int                 tests_run;

	initial sys_clk = 1'h0;
	always #5 sys_clk = ~sys_clk;

	pis_host_model i_host (.sys_clk(sys_clk), .pins(pins));

	pis_shifter i_pis_shifter
	(
		.sys_clk            (sys_clk),
		.rst                (rst),
		.ce                 (ce),
		.shift_load_n       (pins.shift_load_n),
		.shift_clk          (pins.shift_clk),
		.clock_inhibit      (pins.clock_inhibit),
		.serial_in          (pins.serial_in),
		.par_in             (pins.par_in),
		.serial_out         (serial_out),
		.serial_out_inverted(serial_out_inverted)
	);

	function automatic logic [N-1:0] shifted(input logic [N-1:0] v,
		input logic si);
		return {v[N-2:0], si};
	endfunction

	task automatic check_out(input string nm);
		`CHK(nm, exp_q[N-1], serial_out)
		`CHK(nm, ~exp_q[N-1], serial_out_inverted)
	endtask

	task automatic end_sim();
		$display("tests_run %0d err_count %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		rst = 1'h1;
		ce = 1'h1;
		err_count = 0;
		tests_run = 0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'h0;
		void'($urandom(54));
		for (int t = 0; t < 20; t++)
		begin
			exp_q = (t == 0) ? '0 : (t == 1) ? '1 : N'($urandom);
			i_host.load(N'($urandom), exp_q);
			check_out("load");
			ce <= 1'h0;
			repeat (3) @(posedge sys_clk);
			ce <= 1'h1;
			check_out("freeze");
			for (int k = 0; k < N; k++)
			begin
				s = 1'($urandom);
				m = 1'($urandom);
				i_host.shift(m, s);
				exp_q = shifted(exp_q, s);
				check_out("shift");
			end
			i_host.quiet();
			// the first clock rise of the quiet pattern is itself one shift
			exp_q = shifted(exp_q, ~s);
			check_out("quiet");
			$display("test %0d done", t);
		end
		end_sim();
	end

	// about 124 cycles per test, so this leaves wide margin
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		end_sim();
	end
endmodule

/* inc/pis_pkg.sv */
// Purpose: shared constants and pin bundle for the parallel-in shifter
// Assumes: one 100 MHz system clock; all pins asynchronous to it
// Notes:   stage 0 takes the serial input, the last stage drives the output
package pis_pkg;

	localparam int unsigned PIS_STAGES     = 8;
	localparam int unsigned PIS_SYNC_DEPTH = 2;
	localparam int unsigned PIS_PIN_WIDTH  = PIS_STAGES + 4;
	localparam logic        PIS_SYNC_RESET = 1'h0;
	localparam logic        PIS_EDGE_RESET = 1'h0;

	typedef struct packed {
		logic                  shift_load_n;
		logic                  shift_clk;
		logic                  clock_inhibit;
		logic                  serial_in;
		logic [PIS_STAGES-1:0] par_in;
	} pis_pins_s;

	// synchronised pins come out of reset in shift mode with both clocks low;
	// if they came out as zeros, every reset would look like a parallel load
	localparam pis_pins_s PIS_PINS_IDLE =
		'{shift_load_n: 1'h1, default: '0};

endpackage

/* verilog/pis_shifter.sv */
// Purpose: eight-stage parallel-in serial-out shift register
// Assumes: every control and data pin is asynchronous to sys_clk
// Notes:   shift clock and inhibit are sampled, so each level must hold
//          for at least two sys_clk periods to be seen
// Behaviour
// R1 - a rising shift clock with shift/load high moves the stages one place
// R2 - inhibit high or shift clock high with shift/load high: no change
// R3 - inhibit rising while shift clock low also shifts once
// R4 - host raises inhibit only while the shift clock is high; the bench host model also raises it while the clock is low
// R5 - shift/load low copies parallel inputs, whatever else; load beats shift
// R6 - parallel inputs ignored whenever shift/load is high
// R7 - each shift moves every stage one place toward the output
// R8 - each shift takes the serial input into the first stage
// R9 - outputs are the last stage and its complement only
// R10 - eight stages, each with its own parallel input
// R11 - no reset of the stages; contents unknown until loaded
// R12 - load is a level override holding stages equal to the inputs
`timescale 1ns/10ps

module pis_shifter
#(
	parameter int unsigned STAGES = pis_pkg::PIS_STAGES
)
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic              shift_load_n,
	input  wire logic              shift_clk,
	input  wire logic              clock_inhibit,
	input  wire logic              serial_in,
	input  wire logic [STAGES-1:0] par_in,
	output logic                   serial_out,
	output logic                   serial_out_inverted
);

	pis_pkg::pis_pins_s pins_raw;
	pis_pkg::pis_pins_s pins_s;

	logic              clk_comb;
	logic              clk_comb_q;
	logic              clk_comb_d;
	logic              shift_go;
	logic              load_go;
	logic [STAGES-1:0] stage_q;
	logic [STAGES-1:0] stage_d;
	logic              out_q;
	logic              out_d;
	logic              out_inv_q;
	logic              out_inv_d;

	always_comb
	begin
		pins_raw.shift_load_n  = shift_load_n;
		pins_raw.shift_clk     = shift_clk;
		pins_raw.clock_inhibit = clock_inhibit;
		pins_raw.serial_in     = serial_in;
		pins_raw.par_in        = par_in;
	end

	pis_sync
	#(
		.WIDTH     ($bits(pis_pkg::pis_pins_s)),
		.RESET_VAL (pis_pkg::PIS_PINS_IDLE) // [R6] [R11]
	)
	u_sync
	(
		.sys_clk  (sys_clk),
		.rst      (rst),
		.ce       (ce),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	// the two clock pins are interchangeable: their OR is the real clock,
	// so a raise of either while the other is high makes no edge
	assign clk_comb = pins_s.shift_clk | pins_s.clock_inhibit; // [R2] [R3]

	// a host that raises inhibit while the clock is low gets a shift here;
	// nothing in the block can tell that apart from a wanted one
	assign shift_go = ce & pins_s.shift_load_n
		& clk_comb & ~clk_comb_q; // [R1] [R3] [R4]
	assign load_go  = ce & ~pins_s.shift_load_n; // [R5] [R12]

	always_comb
	begin
		clk_comb_d = ce ? clk_comb : clk_comb_q;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			clk_comb_q <= pis_pkg::PIS_EDGE_RESET;
		end
		else
		begin
			clk_comb_q <= clk_comb_d;
		end
	end

	// one mux per stage; stage 0 is fed by the serial input
	genvar gi;
	generate
		for (gi = 0; gi < STAGES; gi++)
		begin : g_stage
			logic shift_src;
			if (gi == 0)
			begin : g_first
				assign shift_src = pins_s.serial_in; // [R8]
			end
			else
			begin : g_rest
				assign shift_src = stage_q[gi-1]; // [R7]
			end
			always_comb
			begin
				if (load_go)
				begin
					stage_d[gi] = pins_s.par_in[gi]; // [R5] [R10] [R12]
				end
				else if (shift_go)
				begin
					stage_d[gi] = shift_src; // [R1] [R6]
				end
				else
				begin
					stage_d[gi] = stage_q[gi]; // [R2]
				end
			end
		end
	endgenerate

	always_comb
	begin
		out_d     = stage_d[STAGES-1]; // [R9]
		out_inv_d = ~stage_d[STAGES-1]; // [R9]
	end

	// deliberately no reset: power-up contents stay unknown until loaded
	always_ff @(posedge sys_clk)
	begin
		stage_q   <= stage_d; // [R11]
		out_q     <= out_d;
		out_inv_q <= out_inv_d;
	end

	assign serial_out          = out_q;
	assign serial_out_inverted = out_inv_q;

	// checks on the stage register and its outputs

	a_load_copies_inputs: assert property ( // [R5]
		@(posedge sys_clk) disable iff (rst)
		(ce && !pins_s.shift_load_n) |=> (stage_q == $past(pins_s.par_in))
	) else $error("stages differ from parallel inputs after load");

	a_load_holds_level: assert property ( // [R12]
		@(posedge sys_clk) disable iff (rst)
		(ce && !pins_s.shift_load_n)[*3] |=>
			(stage_q == $past(pins_s.par_in, 1))
	) else $error("held load did not keep stages equal to inputs");

	a_load_beats_shift: assert property ( // [R5]
		@(posedge sys_clk) disable iff (rst)
		(ce && !pins_s.shift_load_n && clk_comb && !clk_comb_q) |=>
			(stage_q == $past(pins_s.par_in))
	) else $error("clock edge overrode a parallel load");

	a_clk_rise_shifts: assert property ( // [R1]
		@(posedge sys_clk) disable iff (rst)
		(ce && pins_s.shift_load_n && !pins_s.clock_inhibit
			&& pins_s.shift_clk && !clk_comb_q) |=>
			(stage_q[STAGES-1:1] == $past(stage_q[STAGES-2:0]))
	) else $error("clock rise did not shift");

	a_inhibit_rise_shifts: assert property ( // [R3]
		@(posedge sys_clk) disable iff (rst)
		(ce && pins_s.shift_load_n && !pins_s.shift_clk
			&& pins_s.clock_inhibit && !clk_comb_q) |=>
			(stage_q[0] == $past(pins_s.serial_in))
	) else $error("inhibit rise with clock low did not shift");

	a_no_change_high: assert property ( // [R2]
		@(posedge sys_clk) disable iff (rst)
		(ce && pins_s.shift_load_n && clk_comb_q) |=> $stable(stage_q)
	) else $error("stages moved while clock or inhibit was high");

	a_par_ignored: assert property ( // [R6]
		@(posedge sys_clk) disable iff (rst)
		(ce && pins_s.shift_load_n && !shift_go) ##1 $changed(pins_s.par_in)
			|-> $stable(stage_q)
	) else $error("parallel inputs leaked in with shift/load high");

	a_serial_into_first: assert property ( // [R8]
		@(posedge sys_clk) disable iff (rst)
		shift_go |=> (stage_q[0] == $past(pins_s.serial_in))
	) else $error("first stage missed the serial input");

	a_out_is_last: assert property ( // [R9]
		@(posedge sys_clk) disable iff (rst)
		(load_go || shift_go) |=> (serial_out == stage_q[STAGES-1]
			&& serial_out_inverted == !stage_q[STAGES-1])
	) else $error("outputs do not follow the last stage");

	a_ce_freezes: assert property (
		@(posedge sys_clk) disable iff (rst)
		!ce |=> ($stable(stage_q) && $stable(serial_out))
	) else $error("state moved while clock enable was low");

endmodule

/* verilog/pis_sync.sv */
// Purpose: two-flop synchroniser for a bundle of asynchronous pins
// Assumes: bits are independent levels; no word coherence is promised
// Notes:   the first flop is read only by the second
`timescale 1ns/10ps

module pis_sync
#(
	parameter int unsigned      WIDTH     = pis_pkg::PIS_PIN_WIDTH,
	parameter logic [WIDTH-1:0] RESET_VAL = {WIDTH{pis_pkg::PIS_SYNC_RESET}}
)
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb
	begin
		meta_d = ce ? async_in : meta_q;
		sync_d = ce ? meta_q : sync_q;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule
